// [verilog/mps_pkg.sv]
// Constants and types shared by the maintenance port command block.
package mps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Payload geometry.
  localparam int          PAY_W     = 64;    // Payload width in bits.
  localparam int          LEN_W     = 4;     // Width of the received byte count.
  localparam logic [3:0]  PAY_LEN   = 4'h8;  // Bytes in a well-formed payload.
  localparam int          BY_RSVD   = 0;     // Reserved byte.
  localparam int          BY_TYPE   = 1;     // Message type byte.
  localparam int          BY_OPC    = 2;     // Opcode byte.
  localparam int          BY_UNUSED = 3;     // First unused byte of a command.
  localparam int          BY_STH    = 4;     // Status code high byte.
  localparam int          BY_STL    = 5;     // Status code low byte.
  localparam int          BY_OPND   = 7;     // Operand byte of this command.

  ////////////////////////////////////////////////////////////////////////////
  // Field values.
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;  // Reserved and unused bytes.
  localparam logic [7:0]  MSG_TYPE2   = 8'h02;  // Explicit message type.
  localparam logic [7:0]  OPC_MPORT   = 8'hff;  // Maintenance port control.
  localparam logic [7:0]  OPND_REOPEN = 8'h00;  // Reopen for the next host.
  localparam logic [7:0]  OPND_CLOSE  = 8'h01;  // Close, reset and yield.
  localparam logic [7:0]  EXT_NONE    = 8'h00;  // No extended status defined.

  ////////////////////////////////////////////////////////////////////////////
  // General status codes.
  localparam logic [7:0] GS_SUCCESS    = 8'h00;
  localparam logic [7:0] GS_CONN_FAIL  = 8'h01;
  localparam logic [7:0] GS_NO_RESRC   = 8'h02;
  localparam logic [7:0] GS_PATH_SEG   = 8'h04;
  localparam logic [7:0] GS_PATH_DEST  = 8'h05;
  localparam logic [7:0] GS_PARTIAL    = 8'h06;
  localparam logic [7:0] GS_CONN_LOST  = 8'h07;
  localparam logic [7:0] GS_NO_SERVICE = 8'h08;
  localparam logic [7:0] GS_BAD_ATTR   = 8'h09;
  localparam logic [7:0] GS_ATTR_LIST  = 8'h0a;
  localparam logic [7:0] GS_ALREADY    = 8'h0b;
  localparam logic [7:0] GS_OBJ_STATE  = 8'h0c;
  localparam logic [7:0] GS_OBJ_EXISTS = 8'h0d;
  localparam logic [7:0] GS_NOT_SET    = 8'h0e;
  localparam logic [7:0] GS_PRIVILEGE  = 8'h0f;
  localparam logic [7:0] GS_DEV_STATE  = 8'h10;
  localparam logic [7:0] GS_REPLY_BIG  = 8'h11;
  localparam logic [7:0] GS_FRAGMENT   = 8'h12;
  localparam logic [7:0] GS_TOO_LITTLE = 8'h13;
  localparam logic [7:0] GS_ATTR_NOSUP = 8'h14;
  localparam logic [7:0] GS_TOO_MUCH   = 8'h15;
  localparam logic [7:0] GS_NO_OBJECT  = 8'h16;
  localparam logic [7:0] GS_NO_FRAGSEQ = 8'h17;
  localparam logic [7:0] GS_NO_STORED  = 8'h18;
  localparam logic [7:0] GS_STORE_FAIL = 8'h19;
  localparam logic [7:0] GS_BAD_PARAM  = 8'h20;

  // Error flag inputs, lowest index wins; path faults come first since
  // path processing stops at them.
  localparam int NUM_ERR = 21;
  localparam logic [7:0] ERR_CODE [NUM_ERR] = '{
    GS_PATH_SEG, GS_PATH_DEST, GS_CONN_FAIL, GS_CONN_LOST, GS_NO_RESRC,
    GS_PRIVILEGE, GS_DEV_STATE, GS_OBJ_STATE, GS_NO_OBJECT, GS_OBJ_EXISTS,
    GS_ATTR_NOSUP, GS_NOT_SET, GS_BAD_ATTR, GS_ATTR_LIST, GS_FRAGMENT,
    GS_NO_FRAGSEQ, GS_NO_STORED, GS_STORE_FAIL, GS_PARTIAL, GS_REPLY_BIG,
    GS_BAD_PARAM};

  ////////////////////////////////////////////////////////////////////////////
  // State encodings, Gray on each step except 11 to 00 and free to closed, which flip two bits.
  typedef enum logic [1:0] {
    CMD_IDLE    = 2'b00,
    CMD_DECODE  = 2'b01,
    CMD_RESPOND = 2'b11
  } mps_cmd_state_type;

  typedef enum logic [1:0] {
    PORT_FREE   = 2'b00,
    PORT_HELD   = 2'b01,
    PORT_CLOSED = 2'b11
  } mps_port_state_type;

endpackage

// [verilog/mps_status_enc.sv]
// Priority encoder from service error flags to a general status code.
`timescale 1ns/1ps
`default_nettype none
module mps_status_enc #(
  parameter int N = mps_pkg::NUM_ERR  // Number of error flags.
) (
  input  wire logic [N-1:0] flags,  // Error conditions, active high.
  output logic              hit,    // Some flag is set.
  output logic [7:0]        code    // Code of the winning flag.
);

  ////////////////////////////////////////////////////////////////////////////
  // Lowest set index wins; scanning downward lets it overwrite the rest.
  function automatic logic [7:0] pick(input logic [N-1:0] f);
    logic [7:0] c;
    c = mps_pkg::GS_SUCCESS;
    for (int i = N - 1; i >= 0; i--) begin
      if (f[i]) begin
        c = mps_pkg::ERR_CODE[i];
      end
    end
    return c;
  endfunction

  // Combinational; the caller registers the result.
  always_comb begin
    hit  = |flags;
    code = pick(flags);
  end

endmodule // mps_status_enc
`default_nettype wire

// [verilog/mps_port_ctl.sv]
// Maintenance port state: free, held by one host, or closed.
`timescale 1ns/1ps
`default_nettype none
module mps_port_ctl (
  input  wire logic                        clk,        // System clock.
  input  wire logic                        rst_n,      // Synchronous reset, low.
  input  wire logic                        close_req,  // Close and yield, pulse.
  input  wire logic                        open_req,   // Reopen, pulse.
  input  wire logic                        conn_req,   // Host connect attempt, pulse.
  input  wire logic                        conn_drop,  // Host leaves, pulse.
  output mps_pkg::mps_port_state_type      state,      // Current port state.
  output logic                             conn_ack,   // Attempt accepted, pulse.
  output logic                             conn_nak    // Attempt refused, pulse.
);

  mps_pkg::mps_port_state_type next_state;  // Next port state.
  logic                        next_ack;    // Next accept pulse.
  logic                        next_nak;    // Next refuse pulse.

  ////////////////////////////////////////////////////////////////////////////
  // Close beats a same-cycle attempt so a yielding host cannot be replaced
  // by a racing connect before the reopen.
  always_comb begin
    next_state = state;
    next_ack   = 1'b0;
    next_nak   = 1'b0;
    case (state)
      mps_pkg::PORT_FREE: begin
        if (close_req) begin
          next_state = mps_pkg::PORT_CLOSED;
          next_nak   = conn_req;
        end else if (conn_req) begin
          next_state = mps_pkg::PORT_HELD;
          next_ack   = 1'b1;
        end
      end
      mps_pkg::PORT_HELD: begin
        next_nak = conn_req;
        if (close_req) begin
          next_state = mps_pkg::PORT_CLOSED;
        end else if (conn_drop) begin
          next_state = mps_pkg::PORT_FREE;
        end
      end
      mps_pkg::PORT_CLOSED: begin
        next_nak = conn_req;
        if (open_req) begin
          next_state = mps_pkg::PORT_FREE;
        end
      end
      default: begin
        next_state = mps_pkg::PORT_FREE;
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= mps_pkg::PORT_FREE;
      conn_ack <= 1'b0;
      conn_nak <= 1'b0;
    end else begin
      state    <= next_state;
      conn_ack <= next_ack;
      conn_nak <= next_nak;
    end
  end

endmodule // mps_port_ctl
`default_nettype wire

// [verilog/mps_maint_port.sv]
// Command interpreter for maintenance port control and status replies.
//
// Function
// - Command is eight bytes: type 2, opcode FF.
// - Operand one closes port, yields current host.
// - Reply: type 2, opcode echo, status bytes 4-5.
// - Closed port refuses hosts until operand zero.
// - Successful service reports general status zero.
// - Codes 01, 02, 07 for connection faults.
// - Invalid parameter reported as 0x20, not 03.
// - Path faults stop processing: codes 04, 05.
// - State codes 0B, 0C and 10.
// - Size codes 06, 11, 13, 15.
// - Attribute codes 09, 0E, 14, 0A.
// - Object codes 08, 0D, 16.
// - Codes 0F, 12, 17, 18, 19.
// - Extended status undefined, so reported as reserved.
// - One maintenance host at a time.
`timescale 1ns/1ps
`default_nettype none
module mps_maint_port #(
  parameter int N_ERR = mps_pkg::NUM_ERR  // Service error flag count.
) (
  input  wire logic                        MCLK,       // System clock, 100 MHz.
  input  wire logic                        RST_N,      // Synchronous reset, low.
  input  wire logic                        CMD_VALID,  // Command payload offered.
  input  wire logic [mps_pkg::PAY_W-1:0]   CMD_DATA,   // Payload, byte 0 low.
  input  wire logic [mps_pkg::LEN_W-1:0]   CMD_LEN,    // Bytes actually received.
  input  wire logic [N_ERR-1:0]            CMD_ERR,    // Service error flags.
  output logic                             CMD_READY,  // Command accepted when high.
  output logic                             RSP_VALID,  // Reply payload offered.
  output logic [mps_pkg::PAY_W-1:0]        RSP_DATA,   // Reply payload.
  input  wire logic                        RSP_READY,  // Reply taken when high.
  input  wire logic                        CONN_REQ,   // Host connect attempt.
  input  wire logic                        CONN_DROP,  // Host disconnects.
  output logic                             CONN_ACK,   // Attempt accepted, pulse.
  output logic                             CONN_NAK,   // Attempt refused, pulse.
  output logic                             PORT_OPEN,  // Port accepts a host.
  output logic                             HOST_HELD   // A host owns the port.
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Command sequencer state and its next values.
  mps_pkg::mps_cmd_state_type       state;           // Sequencer state.
  mps_pkg::mps_cmd_state_type       next_state;      // Next sequencer state.
  logic [mps_pkg::PAY_W-1:0]        cmd;             // Captured payload.
  logic [mps_pkg::PAY_W-1:0]        next_cmd;        // Next captured payload.
  logic [mps_pkg::LEN_W-1:0]        len;             // Captured byte count.
  logic [mps_pkg::LEN_W-1:0]        next_len;        // Next byte count.
  logic [N_ERR-1:0]                 err;             // Captured error flags.
  logic [N_ERR-1:0]                 next_err;        // Next error flags.
  logic                             next_cmd_ready;  // Next ready level.
  logic                             next_rsp_valid;  // Next reply valid.
  logic [mps_pkg::PAY_W-1:0]        next_rsp_data;   // Next reply payload.
  logic                             do_close;        // Close pulse to port.
  logic                             next_do_close;   // Next close pulse.
  logic                             do_open;         // Reopen pulse to port.
  logic                             next_do_open;    // Next reopen pulse.

  // Decode results, combinational from the captured command.
  logic [7:0]                       dec_code;        // General status chosen.
  logic                             dec_close;       // Command closes port.
  logic                             dec_open;        // Command reopens port.
  logic                             zeros_ok;        // Reserved and unused bytes all zero.
  logic                             enc_hit;         // A service error is set.
  logic [7:0]                       enc_code;        // Its status code.

  // Port state from the port controller.
  mps_pkg::mps_port_state_type      port_state;      // Free, held or closed.
  logic                             next_port_open;  // Next open indication.
  logic                             next_host_held;  // Next held indication.

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Byte lane select, used for every field of the payload.
  function automatic logic [7:0] get_byte(input logic [mps_pkg::PAY_W-1:0] d,
                                          input int idx);
    return d[idx*8 +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Submodules.

  // Error flags to general status, lowest flag index first.
  mps_status_enc #(
    .N     (N_ERR)
  ) u_enc (
    .flags (err),
    .hit   (enc_hit),
    .code  (enc_code)
  );

  // The port keeps its own state so connect attempts are judged even while
  // a command is being decoded.
  mps_port_ctl u_port (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .close_req (do_close),
    .open_req  (do_open),
    .conn_req  (CONN_REQ),
    .conn_drop (CONN_DROP),
    .state     (port_state),
    .conn_ack  (CONN_ACK),
    .conn_nak  (CONN_NAK)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the captured command.

  // Checks run from framing outward to the operand, so a short or long
  // payload is never mistaken for an operand error.
  always_comb begin
    dec_code  = mps_pkg::GS_SUCCESS;
    dec_close = 1'b0;
    dec_open  = 1'b0;
    zeros_ok  = (get_byte(cmd, mps_pkg::BY_RSVD) == mps_pkg::BYTE_ZERO);
    for (int b = mps_pkg::BY_UNUSED; b < mps_pkg::BY_OPND; b++) begin
      // Bytes 3 to 6 carry nothing for this opcode.
      if (get_byte(cmd, b) != mps_pkg::BYTE_ZERO) begin
        zeros_ok = 1'b0;
      end
    end
    if (len < mps_pkg::PAY_LEN) begin
      dec_code = mps_pkg::GS_TOO_LITTLE;
    end else if (len > mps_pkg::PAY_LEN) begin
      dec_code = mps_pkg::GS_TOO_MUCH;
    end else if (get_byte(cmd, mps_pkg::BY_TYPE) != mps_pkg::MSG_TYPE2 ||
                 get_byte(cmd, mps_pkg::BY_OPC) != mps_pkg::OPC_MPORT) begin
      // Only the port control service lives here.
      dec_code = mps_pkg::GS_NO_SERVICE;
    end else if (!zeros_ok) begin
      dec_code = mps_pkg::GS_BAD_PARAM;
    end else if (get_byte(cmd, mps_pkg::BY_OPND) != mps_pkg::OPND_CLOSE &&
                 get_byte(cmd, mps_pkg::BY_OPND) != mps_pkg::OPND_REOPEN) begin
      // Unknown operand leaves the port alone.
      dec_code = mps_pkg::GS_BAD_PARAM;
    end else if (enc_hit) begin
      // A fault reported by the rest of the device blocks the action.
      dec_code = enc_code;
    end else if (get_byte(cmd, mps_pkg::BY_OPND) == mps_pkg::OPND_CLOSE) begin
      if (port_state == mps_pkg::PORT_CLOSED) begin
        dec_code = mps_pkg::GS_ALREADY;
      end else begin
        dec_close = 1'b1;
      end
    end else begin
      // Reopen only from closed; an open port is already in that state.
      if (port_state == mps_pkg::PORT_CLOSED) begin
        dec_open = 1'b1;
      end else begin
        dec_code = mps_pkg::GS_ALREADY;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer: capture, decode, hold reply until taken.

  // One command is in flight at a time; CMD_READY stays low from capture
  // until the reply is taken, which is the only back-pressure needed.
  always_comb begin
    next_state     = state;
    next_cmd       = cmd;
    next_len       = len;
    next_err       = err;
    next_cmd_ready = CMD_READY;
    next_rsp_valid = RSP_VALID;
    next_rsp_data  = RSP_DATA;
    next_do_close  = 1'b0;
    next_do_open   = 1'b0;
    case (state)
      mps_pkg::CMD_IDLE: begin
        // Take a command whenever one is offered.
        if (CMD_VALID && CMD_READY) begin
          next_cmd       = CMD_DATA;
          next_len       = CMD_LEN;
          next_err       = CMD_ERR;
          next_cmd_ready = 1'b0;
          next_state     = mps_pkg::CMD_DECODE;
        end
      end
      mps_pkg::CMD_DECODE: begin
        // Build the reply; every byte not named is zero.
        next_rsp_data = '0;
        next_rsp_data[mps_pkg::BY_TYPE*8 +: 8] = mps_pkg::MSG_TYPE2;
        next_rsp_data[mps_pkg::BY_OPC*8 +: 8] =
          get_byte(cmd, mps_pkg::BY_OPC);
        next_rsp_data[mps_pkg::BY_STH*8 +: 8] = mps_pkg::EXT_NONE;
        next_rsp_data[mps_pkg::BY_STL*8 +: 8] = dec_code;
        next_rsp_valid = 1'b1;
        next_do_close  = dec_close;
        next_do_open   = dec_open;
        next_state     = mps_pkg::CMD_RESPOND;
      end
      mps_pkg::CMD_RESPOND: begin
        // Hold the reply steady until the host side takes it.
        if (RSP_READY) begin
          next_rsp_valid = 1'b0;
          next_cmd_ready = 1'b1;
          next_state     = mps_pkg::CMD_IDLE;
        end
      end
      default: begin
        next_rsp_valid = 1'b0;
        next_cmd_ready = 1'b1;
        next_state     = mps_pkg::CMD_IDLE;
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state     <= mps_pkg::CMD_IDLE;
      cmd       <= '0;
      len       <= '0;
      err       <= '0;
      CMD_READY <= 1'b1;
      RSP_VALID <= 1'b0;
      RSP_DATA  <= '0;
      do_close  <= 1'b0;
      do_open   <= 1'b0;
    end else begin
      state     <= next_state;
      cmd       <= next_cmd;
      len       <= next_len;
      err       <= next_err;
      CMD_READY <= next_cmd_ready;
      RSP_VALID <= next_rsp_valid;
      RSP_DATA  <= next_rsp_data;
      do_close  <= next_do_close;
      do_open   <= next_do_open;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port indications.

  // Registered copies so the top outputs come from flip-flops; they trail
  // the port state by one cycle, which a host polling them never notices.
  always_comb begin
    next_port_open = (port_state == mps_pkg::PORT_FREE);
    next_host_held = (port_state == mps_pkg::PORT_HELD);
  end

  // Registers only.
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PORT_OPEN <= 1'b1;
      HOST_HELD <= 1'b0;
    end else begin
      PORT_OPEN <= next_port_open;
      HOST_HELD <= next_host_held;
    end
  end

endmodule // mps_maint_port
`default_nettype wire

// [tb/mps_maint_port_checker.sv]
// Concurrent checks on the ports of the maintenance port block.
`timescale 1ns/1ps
`default_nettype none
module mps_maint_port_checker #(
  parameter int N_ERR = mps_pkg::NUM_ERR  // Error flag count.
) (
  input wire logic             MCLK,       // Clock.
  input wire logic             RST_N,      // Reset, low.
  input wire logic             CMD_VALID,  // Command offered.
  input wire logic [63:0]      CMD_DATA,   // Command payload.
  input wire logic [3:0]       CMD_LEN,    // Bytes received.
  input wire logic [N_ERR-1:0] CMD_ERR,    // Error flags.
  input wire logic             CMD_READY,  // Idle.
  input wire logic             RSP_VALID,  // Reply offered.
  input wire logic [63:0]      RSP_DATA,   // Reply payload.
  input wire logic             RSP_READY,  // Reply taken.
  input wire logic             CONN_REQ,   // Connect attempt.
  input wire logic             CONN_DROP,  // Host leaves.
  input wire logic             CONN_ACK,   // Accepted.
  input wire logic             CONN_NAK,   // Refused.
  input wire logic             PORT_OPEN,  // Port free.
  input wire logic             HOST_HELD   // Port owned.
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  logic take;      // Command taken this edge.
  logic frame_ok;  // Well-formed control frame, operand aside.
  assign take     = CMD_VALID && CMD_READY;
  assign frame_ok = CMD_LEN == 4'h8 && CMD_DATA[55:0] == 56'hff0200;
  // A taken command is decoded for one cycle, then answered.
  sequence s_answer;
    !CMD_READY && !RSP_VALID ##1 RSP_VALID;
  endsequence
  rsp_timing_a: assert property (take |=> s_answer)
    else $error("reply not on time");
  rsp_hold_a: assert property (RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP_DATA))
    else $error("reply withdrawn early");
  rsp_frame_a: assert property (RSP_VALID |-> RSP_DATA[63:48] == 16'h0
    && RSP_DATA[39:24] == 16'h0 && RSP_DATA[15:0] == 16'h0200) else $error("reply frame bad");
  opc_echo_a: assert property (take |-> ##2 RSP_DATA[23:16] == $past(CMD_DATA[23:16], 2))
    else $error("opcode not echoed");
  short_cmd_a: assert property (take && CMD_LEN < 4'h8 |-> ##2 RSP_DATA[47:40] == 8'h13)
    else $error("short command status");
  bad_opnd_a: assert property (take && frame_ok && CMD_DATA[63:56] > 8'h01
    |-> ##2 RSP_DATA[47:40] == 8'h20) else $error("bad operand status");
  port_close_a: assert property (take && frame_ok && CMD_ERR == '0
    && CMD_DATA[63:56] == 8'h01 |-> ##5 !PORT_OPEN && !HOST_HELD) else $error("port not closed");
  // Success reply, then the free port shows three edges later.
  sequence s_reopen;
    RSP_DATA[47:40] == 8'h00 ##3 PORT_OPEN;
  endsequence
  // Outputs lag the port state, so an idle cycle before the take keeps them current.
  port_reopen_a: assert property (take && frame_ok && CMD_ERR == '0 && $past(CMD_READY)
    && CMD_DATA[63:56] == 8'h00 && !PORT_OPEN && !HOST_HELD
    |-> ##2 s_reopen) else $error("port not reopened");
  held_src_a: assert property ($rose(HOST_HELD) |-> $past(CONN_ACK))
    else $error("host held without accept");
  conn_ans_a: assert property (CONN_REQ |=> CONN_ACK != CONN_NAK)
    else $error("attempt not answered once");
  conn_quiet_a: assert property (!CONN_REQ |=> !CONN_ACK && !CONN_NAK)
    else $error("answer without attempt");
  one_host_a: assert property (CONN_REQ && HOST_HELD && !$past(CONN_DROP) |=> CONN_NAK)
    else $error("second host accepted");
  rsp_done_a: assert property (RSP_VALID && RSP_READY |=> !RSP_VALID && CMD_READY)
    else $error("reply not released");
endmodule // mps_maint_port_checker
bind mps_maint_port mps_maint_port_checker #(.N_ERR(N_ERR)) u_chk (.MCLK(MCLK), .RST_N(RST_N),
  .CMD_VALID(CMD_VALID), .CMD_DATA(CMD_DATA), .CMD_LEN(CMD_LEN), .CMD_ERR(CMD_ERR),
  .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .RSP_READY(RSP_READY),
  .CONN_REQ(CONN_REQ), .CONN_DROP(CONN_DROP), .CONN_ACK(CONN_ACK), .CONN_NAK(CONN_NAK),
  .PORT_OPEN(PORT_OPEN), .HOST_HELD(HOST_HELD));
`default_nettype wire

// [tb/mps_host_model.sv]
// Host side that takes replies after an adjustable stall.
`timescale 1ns/1ps
`default_nettype none
module mps_host_model (
  input  wire logic       clk,        // System clock.
  input  wire logic       rst_n,      // Synchronous reset, low.
  input  wire logic [3:0] stall,      // Cycles to wait before taking.
  input  wire logic       rsp_valid,  // Reply offered.
  output var  logic       rsp_ready   // Reply taken when high.
);
  logic [3:0] wait_cnt;  // Cycles waited on this reply.
  // Ready is held until the edge that takes the reply, so no reply is lost.
  always_ff @(posedge clk) begin
    if (!rst_n || (rsp_valid && rsp_ready)) begin
      rsp_ready <= 1'b0;
      wait_cnt  <= 4'h0;
    end else if (rsp_valid && wait_cnt >= stall) begin
      rsp_ready <= 1'b1;
    end else if (rsp_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // mps_host_model
`default_nettype wire

// [tb/mps_maint_port_bench.sv]
// Self-checking bench for the maintenance port command block.
`timescale 1ns/1ps
`default_nettype none
module mps_maint_port_bench;
  logic        MCLK = 1'b0;      // Clock.
  logic        RST_N = 1'b0;     // Reset.
  logic        CMD_VALID = 1'b0; // Command strobe.
  logic [63:0] CMD_DATA = '0;    // Payload.
  logic [3:0]  CMD_LEN = 4'h8;   // Length.
  logic [20:0] CMD_ERR = '0;     // Error flags.
  logic        CONN_REQ = 1'b0;  // Connect.
  logic        CONN_DROP = 1'b0; // Disconnect.
  logic [3:0]  stall = 4'h0;     // Host stall.
  logic CMD_READY, RSP_VALID, RSP_READY, CONN_ACK, CONN_NAK, PORT_OPEN, HOST_HELD;
  logic [63:0] RSP_DATA;         // Reply payload.
  int failures = 0;              // Mismatches.
  int num_checks = 0;            // Comparisons.
  bit closed = 1'b0;             // Expected port closed.
  bit held = 1'b0;               // Expected host present.
  logic [7:0] codes [21] = '{8'h04, 8'h05, 8'h01, 8'h07, 8'h02, 8'h0f, 8'h10, 8'h0c,
    8'h16, 8'h0d, 8'h14, 8'h0e, 8'h09, 8'h0a, 8'h12, 8'h17, 8'h18, 8'h19, 8'h06, 8'h11, 8'h20};
  always #5 MCLK = ~MCLK;
  mps_maint_port #(.N_ERR(21)) dut (.MCLK(MCLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID),
    .CMD_DATA(CMD_DATA), .CMD_LEN(CMD_LEN), .CMD_ERR(CMD_ERR), .CMD_READY(CMD_READY),
    .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .RSP_READY(RSP_READY), .CONN_REQ(CONN_REQ),
    .CONN_DROP(CONN_DROP), .CONN_ACK(CONN_ACK), .CONN_NAK(CONN_NAK), .PORT_OPEN(PORT_OPEN),
    .HOST_HELD(HOST_HELD));
  mps_host_model host (.clk(MCLK), .rst_n(RST_N), .stall(stall), .rsp_valid(RSP_VALID),
    .rsp_ready(RSP_READY));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    num_checks++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic results();
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Builds a control command with the given operand.
  function automatic logic [63:0] pay(input logic [7:0] opnd);
    return {opnd, 32'h0, 24'hff0200};
  endfunction
  // Expected general status; length and framing faults outrank the flags.
  function automatic logic [7:0] exp_st(input logic [63:0] d, input logic [3:0] len,
                                        input logic [20:0] e);
    if (len < 4'h8) return 8'h13;
    if (len > 4'h8) return 8'h15;
    if (d[23:8] != 16'hff02) return 8'h08;
    if (d[7:0] != 8'h00 || d[55:24] != 32'h0 || d[63:56] > 8'h01) return 8'h20;
    for (int i = 0; i < 21; i++) if (e[i]) return codes[i];
    if ((d[63:56] == 8'h01) == closed) return 8'h0b;
    return 8'h00;
  endfunction
  task automatic port_chk();
    repeat (2) @(negedge MCLK);
    check({62'h0, PORT_OPEN, HOST_HELD}, {62'h0, !closed && !held, held});
  endtask
  task automatic send(input logic [63:0] d, input logic [3:0] len, input logic [20:0] e);
    logic [7:0] st;
    st = exp_st(d, len, e);
    @(posedge MCLK);
    CMD_VALID <= 1'b1;
    CMD_DATA  <= d;
    CMD_LEN   <= len;
    CMD_ERR   <= e;
    stall     <= 4'($urandom_range(3));
    for (int n = 0; n < 20 && CMD_READY !== 1'b1; n++) @(negedge MCLK);
    check(64'(CMD_READY), 64'h1);
    @(posedge MCLK);
    CMD_VALID <= 1'b0;
    CMD_DATA  <= 64'($urandom);
    for (int n = 0; n < 40 && !(RSP_VALID === 1'b1 && RSP_READY === 1'b1); n++)
      @(negedge MCLK);
    check({62'h0, RSP_VALID, RSP_READY}, 64'h3);
    check(RSP_DATA, {16'h0, st, 16'h0, d[23:16], 16'h0200});
    @(posedge MCLK);
    if (st == 8'h00 && d[63:56] == 8'h01) begin
      closed = 1'b1;
      held = 1'b0;
    end else if (st == 8'h00) begin
      closed = 1'b0;
    end
    port_chk();
  endtask
  // Connect attempt, or a disconnect when drop is set.
  task automatic conn(input bit drop);
    logic want;
    want = !closed && !held;
    @(posedge MCLK);
    CONN_REQ  <= !drop;
    CONN_DROP <= drop;
    @(posedge MCLK);
    CONN_REQ  <= 1'b0;
    CONN_DROP <= 1'b0;
    @(negedge MCLK);
    check({62'h0, CONN_ACK, CONN_NAK}, drop ? 64'h0 : {62'h0, want, !want});
    held = drop ? 1'b0 : (held | want);
    port_chk();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge MCLK);
    failures++;
    results();
  end
  initial begin
    logic [20:0] e;
    void'($urandom(32'h16224f4c));
    repeat (16) @(posedge MCLK);
    RST_N <= 1'b1;
    @(negedge MCLK);
    check({61'h0, CMD_READY, PORT_OPEN, HOST_HELD}, 64'h6);
    conn(0); conn(0); conn(1); conn(0);
    send(pay(8'h01), 4'h8, '0);
    conn(0);
    send(pay(8'h01), 4'h8, '0);
    send(pay(8'h00), 4'h8, '0);
    send(pay(8'h00), 4'h8, '0);
    send(pay(8'h00), 4'h7, '0);
    send(pay(8'h01), 4'h9, '0);
    send(pay(8'h01) ^ 64'h10000, 4'h8, '0);
    send(pay(8'h01) ^ 64'h100, 4'h8, '0);
    send(pay(8'h01) | 64'h5000000, 4'h8, '0);
    send(pay(8'($urandom_range(255, 2))), 4'h8, '1);
    for (int i = 0; i < 21; i++) begin
      e = 21'(($urandom << (i + 1)) | (32'h1 << i));
      send(pay(8'($urandom_range(1))), 4'h8, e);
    end
    for (int k = 0; k < 40; k++) begin
      e = ($urandom_range(3) == 0) ? 21'($urandom) : '0;
      send(pay(($urandom_range(4) == 0) ? 8'($urandom) : 8'($urandom_range(1))),
           4'($urandom_range(9, 7)), e);
      if ($urandom_range(2) == 0) conn(1'($urandom_range(1)));
    end
    results();
  end
endmodule // mps_maint_port_bench
`default_nettype wire
